// ---- design/serial_link_lane_config_regs.sv ----
// Design: lane configuration and status register bank for the serial transmit lanes
//
// Overview of operation
// - Read-only density flag and control-words count, 0x80
// - Power-down bit per output, even bits, reset 0xaa
// - Three-bit field picks logical lane per output
// - Reset loads same-index lane map; outputs carry lane 0 until first clock after reset
`timescale 1ns/1ps
`default_nettype none

module serial_link_lane_config_regs
  import lane_cfg_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire bus_req_type            bus_req,
  output logic [DATA_W-1:0]           rdata_ff,
  output logic [LANES-1:0]            lane_off_ff,
  output logic [LANES*SEL_W-1:0]      lane_sel_ff,
  output logic [SWING_W-1:0]          swing_ff,
  output logic                        high_density_flag_ff,
  output logic [CF_W-1:0]             ctrl_words_per_frame_clock_ff
);

  //--------------------------------------------------------------
  // Register storage
  //--------------------------------------------------------------
  logic [DATA_W-1:0] power_down_ff;
  logic [DATA_W-1:0] assign_ff [LANES];
  logic [DATA_W-1:0] swing_reg_ff;
  logic [DATA_W-1:0] nxt_rdata;

  localparam logic [DATA_W-1:0] ASSIGN_RST [LANES] =
    '{RST_ASSIGN0, RST_ASSIGN1, RST_ASSIGN2, RST_ASSIGN3};
  localparam logic [ADDR_W-1:0] ASSIGN_OFS [LANES] =
    '{OFS_ASSIGN0, OFS_ASSIGN1, OFS_ASSIGN2, OFS_ASSIGN3};

  // Power-down register, software writable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_down_ff <= RST_POWER_DOWN;
    end else if (bus_req.wr && bus_req.addr == OFS_POWER_DOWN) begin
      power_down_ff <= bus_req.wdata;
    end
  end

  // Lane assignment registers, one per physical output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LANES; i++) begin
        assign_ff[i] <= ASSIGN_RST[i];
      end
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (bus_req.wr && bus_req.addr == ASSIGN_OFS[i]) begin
          assign_ff[i] <= bus_req.wdata;
        end
      end
    end
  end

  // Drive-level register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      swing_reg_ff <= RST_SWING;
    end else if (bus_req.wr && bus_req.addr == OFS_SWING) begin
      swing_reg_ff <= bus_req.wdata;
    end
  end

  //--------------------------------------------------------------
  // Read mux; read-only values are constants, never written
  //--------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    case (bus_req.addr)
      OFS_DENSITY_CF: nxt_rdata = RST_DENSITY_CF;
      OFS_CHKSUM0:    nxt_rdata = RST_CHKSUM0;
      OFS_CHKSUM1:    nxt_rdata = RST_CHKSUM1;
      OFS_CHKSUM2:    nxt_rdata = RST_CHKSUM2;
      OFS_CHKSUM3:    nxt_rdata = RST_CHKSUM3;
      OFS_POWER_DOWN: nxt_rdata = power_down_ff;
      OFS_ASSIGN0:    nxt_rdata = assign_ff[0];
      OFS_ASSIGN1:    nxt_rdata = assign_ff[1];
      OFS_ASSIGN2:    nxt_rdata = assign_ff[2];
      OFS_ASSIGN3:    nxt_rdata = assign_ff[3];
      OFS_SWING:      nxt_rdata = swing_reg_ff;
      default:        nxt_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (bus_req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  //--------------------------------------------------------------
  // Lane control outputs
  //--------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lane_off_ff                   <= '0;
      lane_sel_ff                   <= '0;
      swing_ff                      <= '0;
      high_density_flag_ff          <= 1'b0;
      ctrl_words_per_frame_clock_ff <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        lane_off_ff[i] <= power_down_ff[i*PD_STRIDE];
        lane_sel_ff[i*SEL_W +: SEL_W] <= assign_ff[i][SEL_LSB +: SEL_W];
      end
      swing_ff                      <= swing_reg_ff[SWING_W-1:0];
      high_density_flag_ff          <= RST_DENSITY_CF[HD_BIT];
      ctrl_words_per_frame_clock_ff <= RST_DENSITY_CF[CF_LSB +: CF_W];
    end
  end

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  a_ro_density_read: assert property (@(posedge mclk) disable iff (rst)
    bus_req.rd && bus_req.addr == OFS_DENSITY_CF |=> rdata_ff == 8'h80)
    else $error("density register read wrong");

  a_ro_link_config_checksum_read: assert property (@(posedge mclk) disable iff (rst)
    bus_req.rd && bus_req.addr == OFS_CHKSUM3 |=> rdata_ff == 8'h84)
    else $error("checksum read wrong");

  a_ro_write_ignored: assert property (@(posedge mclk) disable iff (rst)
    bus_req.wr && bus_req.addr == OFS_CHKSUM0 ##1 bus_req.rd && bus_req.addr == OFS_CHKSUM0
    |=> rdata_ff == 8'h81)
    else $error("write changed checksum");

  a_pd_lane_follow: assert property (@(posedge mclk) disable iff (rst)
    bus_req.wr && bus_req.addr == OFS_POWER_DOWN |=> ##1 lane_off_ff[3] == $past(bus_req.wdata[6], 2))
    else $error("power-down bit not applied");

  a_sel_lane_follow: assert property (@(posedge mclk) disable iff (rst)
    bus_req.wr && bus_req.addr == OFS_ASSIGN2 |=> ##1 lane_sel_ff[8:6] == $past(bus_req.wdata[2:0], 2))
    else $error("lane assignment not applied");

  a_assign_readback: assert property (@(posedge mclk) disable iff (rst)
    bus_req.wr && bus_req.addr == OFS_ASSIGN1 ##1 bus_req.rd && bus_req.addr == OFS_ASSIGN1
    |=> rdata_ff == $past(bus_req.wdata, 2))
    else $error("assignment readback wrong");

  a_idle_rdata_zero: assert property (@(posedge mclk) disable iff (rst)
    !bus_req.rd |=> rdata_ff == 8'h00)
    else $error("read data not cleared");

  a_reset_map_same: assert property (@(posedge mclk)
    $fell(rst) ##1 !$past(bus_req.wr) |-> lane_sel_ff == 12'h688)
    else $error("reset lane mapping wrong");

  // Every output's power-down bit sits on an even register bit
  a_pd_all_lanes: assert property (@(posedge mclk) disable iff (rst)
    bus_req.wr && bus_req.addr == OFS_POWER_DOWN |=> ##1
    lane_off_ff == {$past(bus_req.wdata[6], 2), $past(bus_req.wdata[4], 2),
                    $past(bus_req.wdata[2], 2), $past(bus_req.wdata[0], 2)})
    else $error("power-down bits not applied to all lanes");

  // Density flag and control-word count stay fixed once out of reset
  a_density_fixed_out: assert property (@(posedge mclk) disable iff (rst)
    $past(!rst) |-> high_density_flag_ff && ctrl_words_per_frame_clock_ff == 5'h00)
    else $error("density outputs wrong");

endmodule // serial_link_lane_config_regs

`default_nettype wire

// ---- shared/lane_cfg_pkg.sv ----
// Package: register map, reset values and carrier types for the lane configuration bank
package lane_cfg_pkg;

  localparam int                ADDR_W           = 12;
  localparam int                DATA_W           = 8;
  localparam int                LANES            = 4;
  localparam int                SEL_W            = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_DENSITY_CF   = 12'h592;
  localparam logic [ADDR_W-1:0] OFS_CHKSUM0      = 12'h5a0;
  localparam logic [ADDR_W-1:0] OFS_CHKSUM1      = 12'h5a1;
  localparam logic [ADDR_W-1:0] OFS_CHKSUM2      = 12'h5a2;
  localparam logic [ADDR_W-1:0] OFS_CHKSUM3      = 12'h5a3;
  localparam logic [ADDR_W-1:0] OFS_POWER_DOWN   = 12'h5b0;
  localparam logic [ADDR_W-1:0] OFS_ASSIGN0      = 12'h5b2;
  localparam logic [ADDR_W-1:0] OFS_ASSIGN1      = 12'h5b3;
  localparam logic [ADDR_W-1:0] OFS_ASSIGN2      = 12'h5b5;
  localparam logic [ADDR_W-1:0] OFS_ASSIGN3      = 12'h5b6;
  localparam logic [ADDR_W-1:0] OFS_SWING        = 12'h5bf;

  // Reset values
  localparam logic [DATA_W-1:0] RST_DENSITY_CF   = 8'h80;
  localparam logic [DATA_W-1:0] RST_CHKSUM0      = 8'h81;
  localparam logic [DATA_W-1:0] RST_CHKSUM1      = 8'h82;
  localparam logic [DATA_W-1:0] RST_CHKSUM2      = 8'h82;
  localparam logic [DATA_W-1:0] RST_CHKSUM3      = 8'h84;
  localparam logic [DATA_W-1:0] RST_POWER_DOWN   = 8'haa;
  localparam logic [DATA_W-1:0] RST_ASSIGN0      = 8'h00;
  localparam logic [DATA_W-1:0] RST_ASSIGN1      = 8'h11;
  localparam logic [DATA_W-1:0] RST_ASSIGN2      = 8'h22;
  localparam logic [DATA_W-1:0] RST_ASSIGN3      = 8'h33;
  localparam logic [DATA_W-1:0] RST_SWING        = 8'h00;

  // Field positions
  localparam int                HD_BIT           = 7;
  localparam int                CF_LSB           = 0;
  localparam int                CF_W             = 5;
  localparam int                PD_STRIDE        = 2;
  localparam int                SEL_LSB          = 0;
  localparam int                SWING_W          = 4;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_type;

endpackage

// ---- verification/lane_receiver_model.sv ----
// Partner model: receiver view of the serial lane outputs
`timescale 1ns/1ps
`default_nettype none
module lane_receiver_model
  import lane_cfg_pkg::*;
(
  input  wire logic [0:0]             mclk,
  input  wire logic [LANES-1:0]       lane_off,
  input  wire logic [LANES*SEL_W-1:0] lane_sel,
  output logic      [LANES-1:0]       live_ff,
  output logic      [LANES*SEL_W-1:0] lane_map_ff
);
  // Receiver samples which outputs run and which logical lane each carries
  always_ff @(posedge mclk) begin
    live_ff     <= ~lane_off;
    lane_map_ff <= lane_sel;
  end
endmodule // lane_receiver_model
`default_nettype wire

// ---- verification/tb_serial_link_lane_config_regs.sv ----
// Testbench: register access and lane output checks for the lane bank
`timescale 1ns/1ps
`default_nettype none
module tb_serial_link_lane_config_regs;
  import lane_cfg_pkg::*;
  logic                   mclk;
  logic                   rst;
  bus_req_type            req;
  logic [DATA_W-1:0]      rdata;
  logic [LANES-1:0]       off;
  logic [LANES*SEL_W-1:0] sel;
  logic [LANES-1:0]       live;
  logic [LANES*SEL_W-1:0] map;
  logic [SWING_W-1:0]     swing;
  logic                   hd;
  logic [CF_W-1:0]        cf;
  int                     failures;
  int                     comparisons;
  int                     cycles;
  logic [ADDR_W-1:0]      ofs [10] = '{12'h592, 12'h5a0, 12'h5a1, 12'h5a2, 12'h5a3,
                                       12'h5b0, 12'h5b2, 12'h5b3, 12'h5b5, 12'h5b6};
  logic [DATA_W-1:0]      rv [10] = '{8'h80, 8'h81, 8'h82, 8'h82, 8'h84,
                                      8'haa, 8'h00, 8'h11, 8'h22, 8'h33};

  serial_link_lane_config_regs uut (.mclk(mclk), .rst(rst), .bus_req(req), .rdata_ff(rdata),
    .lane_off_ff(off), .lane_sel_ff(sel), .swing_ff(swing), .high_density_flag_ff(hd),
    .ctrl_words_per_frame_clock_ff(cf));
  lane_receiver_model rx (.mclk(mclk), .lane_off(off), .lane_sel(sel), .live_ff(live),
    .lane_map_ff(map));

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  // Write followed with no gap by a read of the same address
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [DATA_W-1:0] e);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk("rdata", {4'h0, e}, {4'h0, rdata});
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk("rdata", {4'h0, e}, {4'h0, rdata});
  endtask

  task automatic complete_run();
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    req = '0;
    rst = 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk("lane_sel", 12'h688, sel);
    chk("lane_off", 12'h000, {8'h00, off});
    chk("hd_cf", 12'h080, {4'h0, hd, 2'b00, cf});
    for (int i = 0; i < 10; i++) rd(ofs[i], rv[i]);
    for (int i = 0; i < 5; i++) wr(ofs[i], 8'h5a);
    for (int i = 0; i < 5; i++) rd(ofs[i], rv[i]);
    chk("hd_cf", 12'h080, {4'h0, hd, 2'b00, cf});
    wr(OFS_POWER_DOWN, 8'h41);
    repeat (2) @(posedge mclk);
    #1 chk("lane_off", 12'h009, {8'h00, off});
    chk("live", 12'h006, {8'h00, live});
    rd(OFS_POWER_DOWN, 8'h41);
    wr(OFS_ASSIGN0, 8'h03);
    wr(OFS_ASSIGN1, 8'h02);
    wr(OFS_ASSIGN2, 8'h01);
    wr(OFS_ASSIGN3, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk("lane_map", 12'h053, map);
    wr(12'h5b4, 8'hff);
    rd(12'h5b4, 8'h00);
    rd(OFS_ASSIGN0, 8'h03);
    wr_rd(OFS_CHKSUM0, 8'h5a, 8'h81);
    wr_rd(OFS_ASSIGN1, 8'hfa, 8'hfa);
    wr_rd(OFS_SWING, 8'h3c, 8'h3c);
    chk("swing", 12'h00c, {8'h00, swing});
    // Mid-run reset restores the identity map and power-down default
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk("lane_sel", 12'h688, sel);
    chk("lane_off", 12'h000, {8'h00, off});
    rd(OFS_ASSIGN1, 8'h11);
    complete_run();
  end
endmodule // tb_serial_link_lane_config_regs
`default_nettype wire
